// ==== src/fse_pkg.sv ====
// Functional notes
// [RULE_01] K=7 rate-half encoder, zero start
// [RULE_02] Six zero tail bits after header, payload
// [RULE_03] Zero pad payload to half-depth multiple
// [RULE_04] Feed header, tail, payload, tail, pad
// [RULE_05] First generator bit before second, in order
// [RULE_06] Interleaving switched by its own setting
// [RULE_07] Header interleaved as separate block
// [RULE_08] Payload interleaved only with coding active
// [RULE_09] Header block 28 short, 44 long
// [RULE_10] Payload split into 72-bit blocks
// [RULE_11] Interleaver permutation by depth and degree
// [RULE_12] Index zero is earliest bit of block
// [RULE_13] Header block first, payload blocks ascending
// [RULE_14] Deinterleaver inverse mapping defined
// [RULE_15] Spreading enable plus factor 1..16
// [RULE_16] Spreading covers header and payload
// [RULE_17] Chips alternate 0101 or 1010, truncated
// [RULE_18] Whitening has its own setting
// [RULE_19] Degree 4 for headers, 6 for payload
// [RULE_20] Valid/ready stages, whole block before output
package fse_pkg;

  localparam int unsigned ADDR_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_LENGTH = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CMD    = 4'hC;

  // Control field positions
  localparam int unsigned CTRL_FEC     = 0;
  localparam int unsigned CTRL_ILV     = 1;
  localparam int unsigned CTRL_SPREAD  = 2;
  localparam int unsigned CTRL_WHITEN  = 3;
  localparam int unsigned CTRL_LONGHDR = 4;
  localparam int unsigned CTRL_SF_LSB  = 8;
  localparam int unsigned CMD_START    = 0;

  localparam logic [2:0] SF_LOG2_MAX = 3'h4;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // Interleaver geometry
  localparam logic [6:0] N_HDR_SHORT = 7'h1C;
  localparam logic [6:0] N_HDR_LONG  = 7'h2C;
  localparam logic [6:0] N_PAY       = 7'h48;
  localparam logic [2:0] L_HDR       = 3'h4;
  localparam logic [2:0] L_PAY       = 3'h6;
  localparam int unsigned BUF_DEPTH  = 72;
  localparam logic [10:0] TAIL_BITS  = 11'h006;
  localparam logic [10:0] HDR_BITS_SHORT = 11'h008;
  localparam logic [10:0] HDR_BITS_LONG  = 11'h010;

  typedef enum logic [2:0] {
    FSE_IDLE  = 3'b000,
    FSE_HDR   = 3'b001,
    FSE_HTAIL = 3'b010,
    FSE_PAY   = 3'b011,
    FSE_PTAIL = 3'b100,
    FSE_PAD   = 3'b101
  } fse_phase_e;

endpackage : fse_pkg

// ==== src/fse_spreader.sv ====
module fse_spreader
  import fse_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Settings
  input  wire logic       enable,
  input  wire logic [2:0] sf_log2,
  // Bit input
  input  wire logic       in_bit,
  input  wire logic       in_last,
  input  wire logic       in_valid,
  output logic            in_ready,
  // Chip output
  output logic            chip_out,
  output logic            chip_last,
  output logic            chip_valid,
  input  wire logic       chip_ready
);

  typedef struct packed {
    logic       busy;
    logic       chip;
    logic       last;
    logic [4:0] left;
  } fse_spr_s;

  fse_spr_s q;
  fse_spr_s d;
  logic [2:0] eff_log2;
  logic [4:0] chips_m1;

  // Codes above sixteen chips saturate
  assign eff_log2 = (sf_log2 > SF_LOG2_MAX) ? SF_LOG2_MAX : sf_log2;
  // [RULE_15] factor from setting
  assign chips_m1 = enable ? 5'((5'h01 << eff_log2) - 5'h01) : 5'h00;

  // [RULE_20] ready when idle or finishing
  assign in_ready   = !q.busy || (chip_ready && q.left == 5'h00);
  assign chip_valid = q.busy;
  assign chip_out   = q.chip;
  assign chip_last  = q.busy && q.last && q.left == 5'h00;

  always_comb begin
    d = q;
    if (q.busy && chip_ready) begin
      if (q.left == 5'h00) begin
        d.busy = 1'b0;
      end else begin
        d.left = q.left - 5'h01;
        // [RULE_17] alternating chip pattern
        d.chip = ~q.chip;
      end
    end
    if (in_valid && in_ready) begin
      d.busy = 1'b1;
      // [RULE_17] first chip equals bit
      d.chip = in_bit;
      d.last = in_last;
      d.left = chips_m1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule : fse_spreader

// ==== src/fse_codec.sv ====
module fse_codec
  import fse_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]   address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  // Bits from framing
  input  wire logic                in_bit,
  input  wire logic                in_valid,
  output logic                     in_ready,
  // Chips to modulator
  output logic                     chip_out,
  output logic                     chip_valid,
  output logic                     chip_last,
  input  wire logic                chip_ready,
  // Whitening control for framing
  output logic                     whiten_en
);

  typedef struct packed {
    fse_phase_e  phase;
    logic        drain;
    logic        hdr_blk;
    logic [6:0]  wr_k;
    logic [6:0]  rd_i;
    logic [10:0] cnt;
    logic [BUF_DEPTH-1:0] bits;
    logic [5:0]  sr;
    logic [7:0]  blocks;
    logic [7:0]  ctrl;
    logic [2:0]  sf_log2;
    logic [7:0]  length;
    logic        resp;
    logic [31:0] rdata;
  } fse_main_s;

  fse_main_s q;
  fse_main_s d;

  logic       fec;
  logic       ilv;
  logic [6:0] blk_n;
  logic [2:0] blk_l;
  logic [6:0] rd_addr;
  logic       data_ph;
  logic       code_ph;
  logic       u;
  logic       g0;
  logic       g1;
  logic       step;
  logic       spr_bit;
  logic       spr_last;
  logic       spr_valid;
  logic       spr_ready;
  logic [10:0] pay_bits;
  logic [10:0] hdr_bits;

  // [RULE_14] inverse map gives read address
  function automatic logic [6:0] fse_deint(input logic [6:0] i,
                                            input logic [6:0] n,
                                            input logic [2:0] l);
    logic [9:0] t;
    logic [9:0] f;
    logic [9:0] k;
    t = 10'(l) * 10'(n - 7'h01 - i);
    f = t / 10'(n);
    k = t - 10'(n - 7'h01) * f;
    return k[6:0];
  endfunction : fse_deint

  assign fec       = q.ctrl[CTRL_FEC];
  // [RULE_06] [RULE_08] interleave only when coded
  assign ilv       = q.ctrl[CTRL_ILV] && fec;
  // [RULE_18] whitening setting exported
  assign whiten_en = q.ctrl[CTRL_WHITEN];
  assign pay_bits  = {q.length, 3'h0};
  assign hdr_bits  = q.ctrl[CTRL_LONGHDR] ? HDR_BITS_LONG : HDR_BITS_SHORT;

  // [RULE_09] [RULE_10] [RULE_19] block depth and degree
  assign blk_n = q.hdr_blk ? (q.ctrl[CTRL_LONGHDR] ? N_HDR_LONG : N_HDR_SHORT) : N_PAY;
  assign blk_l = q.hdr_blk ? L_HDR : L_PAY;
  // [RULE_11] [RULE_12] output i reads input k
  assign rd_addr = ilv ? fse_deint(q.rd_i, blk_n, blk_l) : q.rd_i;

  assign data_ph = (q.phase == FSE_HDR) || (q.phase == FSE_PAY);
  assign code_ph = (q.phase == FSE_HTAIL) || (q.phase == FSE_PTAIL) ||
                   (q.phase == FSE_PAD && q.wr_k != 7'h00);

  // [RULE_02] [RULE_03] tail and pad feed zeros
  assign u  = data_ph ? in_bit : 1'b0;
  // [RULE_01] generator taps on history
  assign g0 = u ^ q.sr[1] ^ q.sr[2] ^ q.sr[4] ^ q.sr[5];
  assign g1 = u ^ q.sr[0] ^ q.sr[1] ^ q.sr[2] ^ q.sr[5];

  // [RULE_20] upstream stalls while a block drains
  always_comb begin
    if (!fec) begin
      in_ready = data_ph && spr_ready;
      step     = data_ph && in_valid && spr_ready;
    end else begin
      in_ready = data_ph && !q.drain;
      step     = !q.drain && ((data_ph && in_valid) || code_ph);
    end
  end

  always_comb begin
    if (!fec) begin
      spr_valid = data_ph && in_valid;
      spr_bit   = in_bit;
      spr_last  = q.cnt == 11'h001 &&
                  (q.phase == FSE_PAY || (q.phase == FSE_HDR && q.length == 8'h00));
    end else begin
      spr_valid = q.drain;
      spr_bit   = q.bits[rd_addr];
      spr_last  = q.phase == FSE_PAD && q.rd_i == blk_n - 7'h01;
    end
  end

  // Held off while frozen so a write is never lost
  assign waitrequest = (read || write) && (!q.resp || !ce);

  always_comb begin
    d = q;
    // Bus: one wait state, read data loaded alongside
    d.resp = (read || write) && !q.resp;
    if (read && !q.resp) begin
      unique case (address)
        OFS_CTRL:   d.rdata = {21'h000000, q.sf_log2, q.ctrl};
        OFS_LENGTH: d.rdata = {24'h000000, q.length};
        OFS_STATUS: d.rdata = {9'h000, q.wr_k, q.blocks, 4'h0, q.phase,
                               q.phase != FSE_IDLE};
        default:    d.rdata = 32'h00000000;
      endcase
    end
    // Settings locked during a frame to keep geometry stable
    if (write && q.resp && q.phase == FSE_IDLE) begin
      unique case (address)
        OFS_CTRL: begin
          d.ctrl    = writedata[7:0];
          // [RULE_15] factor code stored
          d.sf_log2 = writedata[CTRL_SF_LSB +: 3];
        end
        OFS_LENGTH: d.length = writedata[7:0];
        OFS_CMD: begin
          if (writedata[CMD_START]) begin
            d.phase   = FSE_HDR;
            d.cnt     = hdr_bits;
            d.wr_k    = 7'h00;
            d.rd_i    = 7'h00;
            d.drain   = 1'b0;
            // [RULE_07] header gets its own block
            d.hdr_blk = 1'b1;
            // [RULE_01] encoder starts cleared
            d.sr      = 6'h00;
            d.blocks  = 8'h00;
          end
        end
        default: ;
      endcase
    end

    if (step) begin
      if (fec) begin
        // [RULE_05] first generator bit goes earlier
        d.bits[q.wr_k]         = g0;
        d.bits[q.wr_k + 7'h01] = g1;
        d.wr_k                 = q.wr_k + 7'h02;
        d.sr                   = {q.sr[4:0], u};
        // [RULE_20] full block before any output
        if (q.wr_k + 7'h02 == blk_n) begin
          d.drain = 1'b1;
          d.rd_i  = 7'h00;
        end
      end
      // [RULE_04] segment order
      unique case (q.phase)
        FSE_HDR: begin
          d.cnt = q.cnt - 11'h001;
          if (q.cnt == 11'h001) begin
            if (fec) begin
              d.phase = FSE_HTAIL;
              d.cnt   = TAIL_BITS;
            end else if (q.length == 8'h00) begin
              d.phase = FSE_IDLE;
            end else begin
              d.phase = FSE_PAY;
              d.cnt   = pay_bits;
            end
          end
        end
        FSE_HTAIL: begin
          d.cnt = q.cnt - 11'h001;
          if (q.cnt == 11'h001) begin
            d.phase = (q.length == 8'h00) ? FSE_PTAIL : FSE_PAY;
            d.cnt   = (q.length == 8'h00) ? TAIL_BITS : pay_bits;
          end
        end
        FSE_PAY: begin
          d.cnt = q.cnt - 11'h001;
          if (q.cnt == 11'h001) begin
            d.phase = fec ? FSE_PTAIL : FSE_IDLE;
            d.cnt   = TAIL_BITS;
          end
        end
        FSE_PTAIL: begin
          d.cnt = q.cnt - 11'h001;
          if (q.cnt == 11'h001) begin
            d.phase = FSE_PAD;
          end
        end
        default: ;
      endcase
    end

    // [RULE_13] blocks drained in arrival order
    if (q.drain && spr_ready) begin
      if (q.rd_i == blk_n - 7'h01) begin
        d.drain   = 1'b0;
        d.wr_k    = 7'h00;
        d.hdr_blk = 1'b0;
        d.blocks  = q.blocks + 8'h01;
      end else begin
        d.rd_i = q.rd_i + 7'h01;
      end
    end

    // [RULE_03] pad ends at block boundary
    if (q.phase == FSE_PAD && !q.drain && q.wr_k == 7'h00) begin
      d.phase = FSE_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q       <= '0;
      q.phase <= FSE_IDLE;
      q.ctrl  <= CTRL_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

  assign readdata = q.rdata;

  // [RULE_16] spreading on header and payload alike
  fse_spreader u_spread (
    .clk        (clk),
    .resetn     (resetn),
    .ce         (ce),
    .enable     (q.ctrl[CTRL_SPREAD]),
    .sf_log2    (q.sf_log2),
    .in_bit     (spr_bit),
    .in_last    (spr_last),
    .in_valid   (spr_valid),
    .in_ready   (spr_ready),
    .chip_out   (chip_out),
    .chip_last  (chip_last),
    .chip_valid (chip_valid),
    .chip_ready (chip_ready)
  );

endmodule : fse_codec

// ==== test/fse_codec_sva.sv ====
module fse_codec_sva
  import fse_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              ce,
  // Register bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [31:0]       readdata,
  input wire logic              waitrequest,
  // Chip side
  input wire logic              chip_out,
  input wire logic              chip_valid,
  input wire logic              chip_last,
  input wire logic              chip_ready,
  input wire logic              whiten_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rd_ok;
  logic wr_ctrl;
  assign rd_ok   = read && !waitrequest;
  assign wr_ctrl = write && !waitrequest && (address == OFS_CTRL);
  sequence req_wait_s;
    ce && (read || write) && waitrequest;
  endsequence
  sequence req_done_s;
    ce && (read || write) && !waitrequest;
  endsequence
  bus_wait_a: assert property (req_wait_s |=> waitrequest == !ce)
    else $error("bus answer late");
  bus_once_a: assert property (req_done_s ##1 (read || write) |-> waitrequest)
    else $error("bus answer held too long");
  rdata_hold_a: assert property ($changed(readdata) |-> $past(read))
    else $error("read data moved without a read");
  unmap_zero_a: assert property (rd_ok && address[1:0] != 2'h0 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  cmd_zero_a: assert property (rd_ok && address == OFS_CMD |-> readdata == 32'h0)
    else $error("command read not zero");
  whiten_rd_a: assert property (rd_ok && address == OFS_CTRL |-> readdata[3] == whiten_en)
    else $error("whitening output differs from control");
  whiten_src_a: assert property ($changed(whiten_en) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
    else $error("whitening changed without a write");
  chip_hold_a: assert property (ce && chip_valid && !chip_ready |=> chip_valid && $stable(chip_out))
    else $error("chip dropped while stalled");
  last_valid_a: assert property (chip_last |-> chip_valid)
    else $error("last flag without chip");
  last_end_a: assert property (ce && chip_last && chip_ready |=> !chip_valid)
    else $error("chip after final chip of frame");
endmodule : fse_codec_sva

bind fse_codec fse_codec_sva u_sva (.clk(clk), .resetn(resetn), .ce(ce), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .chip_out(chip_out), .chip_valid(chip_valid), .chip_last(chip_last),
  .chip_ready(chip_ready), .whiten_en(whiten_en));

// ==== test/fse_far_model.sv ====
module fse_far_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  // Bits to the codec
  output logic      in_bit,
  output logic      in_valid,
  input  wire logic in_ready,
  // Chips from the codec
  input  wire logic chip_out,
  input  wire logic chip_valid,
  input  wire logic chip_last,
  output logic      chip_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic   src_q[$];
  logic   got_q[$];
  int     last_pos = 0;
  integer seed = 32'h6515;
  task automatic push_bit(input logic b);
    src_q.push_back(b);
  endtask : push_bit
  task automatic clear;
    got_q.delete();
    last_pos = 0;
  endtask : clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_bit <= 1'h0;
      in_valid <= 1'h0;
      chip_ready <= 1'h0;
    end else begin
      // Transfers only count on enabled edges
      if (ce && chip_valid && chip_ready) begin
        got_q.push_back(chip_out);
        if (chip_last) last_pos = got_q.size();
      end
      // Stalls exercise downstream hold
      chip_ready <= ($random(seed) % 4) != 0;
      if (ce && in_valid && in_ready) void'(src_q.pop_front());
      if (in_valid && !(ce && in_ready)) begin
      end else if (src_q.size() != 0 && ($random(seed) % 3) != 0) begin
        in_valid <= 1'h1;
        in_bit <= src_q[0];
      end else begin
        in_valid <= 1'h0;
        in_bit <= ~in_bit;
      end
    end
  end
endmodule : fse_far_model

// ==== test/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fse_pkg::*;
  logic              clk = 1'h0;
  logic              resetn = 1'h0;
  logic              ce = 1'h1;
  logic              ce_rand = 1'h0;
  logic [ADDR_W-1:0] address = '0;
  logic              read = 1'h0;
  logic              write = 1'h0;
  logic [31:0]       writedata = 32'h0;
  logic [31:0]       readdata, q;
  logic              waitrequest, in_bit, in_valid, in_ready, whiten_en;
  logic              chip_out, chip_valid, chip_last, chip_ready;
  logic              exp_q[$], dat_q[$];
  logic [ADDR_W-1:0] regs[5] = '{OFS_CTRL, OFS_LENGTH, OFS_STATUS, OFS_CMD, 4'h2};
  int                fail_count = 0;
  int                checks_done = 0;
  int                cyc = 0;
  integer            seed = 32'h6515;

  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ce <= ce_rand ? (($random(seed) % 4) != 0) : 1'h1;
    if (cyc == 90000) begin
      fail_count++;
      summarize();
    end
  end

  fse_codec u_dut (.clk(clk), .resetn(resetn), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .in_bit(in_bit), .in_valid(in_valid), .in_ready(in_ready), .chip_out(chip_out),
    .chip_valid(chip_valid), .chip_last(chip_last), .chip_ready(chip_ready),
    .whiten_en(whiten_en));
  fse_far_model u_far (.clk(clk), .resetn(resetn), .ce(ce), .in_bit(in_bit),
    .in_valid(in_valid), .in_ready(in_ready), .chip_out(chip_out), .chip_valid(chip_valid),
    .chip_last(chip_last), .chip_ready(chip_ready));

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_stream;
    int bad = (u_far.got_q.size() != exp_q.size());
    foreach (exp_q[i]) if (i < u_far.got_q.size() && u_far.got_q[i] !== exp_q[i]) bad++;
    checks_done++;
    if (bad != 0) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, u_far.got_q.size(), bad + exp_q.size());
    end
  endtask : chk_stream
  // Held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'h0);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask : bus
  task automatic add_chips(input logic b, input logic spr, input int sf);
    for (int j = 0; j < (spr ? (1 << sf) : 1); j++) exp_q.push_back(b ^ j[0]);
  endtask : add_chips
  task automatic build(input logic [4:0] f, input int sf, input int len);
    logic       cq[$];
    logic       ob[72];
    logic       u;
    logic [5:0] st = 6'h00;
    int hn = f[4] ? 16 : 8;
    int nd = 36 * ((8 * len + 41) / 36);
    int base = 0;
    int n, l;
    exp_q.delete();
    if (!f[0]) begin
      foreach (dat_q[i]) add_chips(dat_q[i], f[2], sf);
      return;
    end
    for (int i = 0; i < hn + 6 + nd; i++) begin
      u = (i < hn) ? dat_q[i] : (i >= hn + 6 && i < hn + 6 + 8 * len) ? dat_q[i-6] : 1'h0;
      cq.push_back(u ^ st[1] ^ st[2] ^ st[4] ^ st[5]);
      cq.push_back(u ^ st[0] ^ st[1] ^ st[2] ^ st[5]);
      st = {st[4:0], u};
    end
    while (base < cq.size()) begin
      n = (base == 0) ? 2 * (hn + 6) : 72;
      l = (base == 0) ? 4 : 6;
      for (int k = 0; k < n; k++) ob[f[1] ? (n/l)*((n-1-k)%l) + (n-1-k)/l : k] = cq[base+k];
      for (int i = 0; i < n; i++) add_chips(ob[i], f[2], sf);
      base += n;
    end
  endtask : build
  // Settings bits follow the control layout: fec, ilv, spread, whiten, long header
  task automatic run_frame(input logic [4:0] f, input logic [2:0] sf, input logic [7:0] len);
    int t = 0;
    dat_q.delete();
    for (int i = 0; i < (f[4] ? 16 : 8) + 8 * len; i++) dat_q.push_back(1'($random(seed)));
    build(f, sf, len);
    u_far.clear();
    bus(1'h1, OFS_CTRL, {21'h0, sf, 3'h0, f});
    bus(1'h1, OFS_LENGTH, {24'h0, len});
    foreach (dat_q[i]) u_far.push_bit(dat_q[i]);
    bus(1'h1, OFS_CMD, 32'h1);
    while (u_far.got_q.size() < exp_q.size() && t < 30000) begin
      @(posedge clk);
      t++;
    end
    repeat (8) @(posedge clk);
    chk_stream();
    chk_word(u_far.last_pos, exp_q.size());
    chk_word({31'h0, whiten_en}, {31'h0, f[3]});
    bus(1'h0, OFS_CTRL, 32'h0);
    chk_word(q, {21'h0, sf, 3'h0, f});
    bus(1'h0, OFS_STATUS, 32'h0);
    chk_word({31'h0, q[0]}, 32'h0);
    $display("frame %h sf %0d len %0d chips %0d done", f, sf, len, exp_q.size());
  endtask : run_frame
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    foreach (regs[i]) begin
      bus(1'h0, regs[i], 32'h0);
      chk_word(q, 32'h0);
    end
    bus(1'h1, 4'h2, 32'hFFFF_FFFF);
    bus(1'h0, OFS_CTRL, 32'h0);
    chk_word(q, 32'h0);
    $display("register test done");
    for (int s = 0; s < 5; s++) run_frame(5'h06, 3'(s), 8'h01);
    run_frame(5'h03, 3'h0, 8'h00);
    run_frame(5'h11, 3'h0, 8'h03);
    run_frame(5'h17, 3'h2, 8'h02);
    run_frame(5'h0B, 3'h1, 8'h04);
    // Clock-enable gaps over the random frames
    ce_rand <= 1'h1;
    repeat (4) run_frame(5'($random(seed)), 3'($unsigned($random(seed)) % 5),
                         8'($unsigned($random(seed)) % 5));
    summarize();
  end
endmodule : tb_top
